// ### core/cmc_config_regs.sv
// Purpose: Manufacturer configuration register bank of a managed converter.
// Assumes: A PMBus transport decodes each command into one cycle strobe.
// Notes:   All outputs are registered; responses come one cycle after a command.
module cmc_config_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Decoded PMBus command
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [31:0] cmdWrData,
  input wire logic cmdPecOk,
  // Command response
  output logic rspValid,
  output logic rspNack,
  output logic [31:0] rspData,
  // Event recorder
  input wire logic [4:0] lifeRecordCount,
  output logic [7:0] eventIdx,
  output logic eventLifeSection,
  output logic [7:0] eventOffset,
  output logic faultClear,
  // Temperature
  input wire logic [15:0] intTempRaw,
  input wire logic [15:0] extAdcRaw,
  output logic useExternalSensor,
  output logic [15:0] tempReading,
  // Trims
  output logic [15:0] vinTrimOn,
  output logic [15:0] vinTrimOff,
  output logic [15:0] voutTrim,
  // Regulation options
  output logic pecRequired,
  output logic hybridRatioMode,
  output logic droopSlopeShape,
  output logic adaptiveRampLoadComp,
  output logic dynamicBusVoltageMode,
  // Remote on/off
  input wire logic primaryRemoteInput,
  input wire logic ctrlPin,
  input wire logic operationOn,
  output logic outputOn,
  output logic softStopReq,
  output logic quickOffReq
);

  // -----------------------------------------------------------------------
  // Register storage
  // -----------------------------------------------------------------------
  logic [7:0] eventPtr_reg;
  logic [7:0] tempSel_reg;
  logic [31:0] vinTrim_reg;
  logic [15:0] voutTrim_reg;
  logic [7:0] regOpts_reg;
  logic [15:0] intTempOfs_reg;
  logic [31:0] extTempCal_reg;
  logic [7:0] remoteCfg_reg;

  logic [7:0] newestLifeIdx;
  logic knownCode;
  logic pecBlocked;
  logic wrStrobe;
  logic [31:0] rdValue;

  // -----------------------------------------------------------------------
  // Command qualification
  // -----------------------------------------------------------------------
  always_comb begin
    if (cmdCode == cmc_pkg::CMD_EVENT_PTR) begin
      knownCode = 1'b1;
    end else if (cmdCode == cmc_pkg::CMD_TEMP_SEL) begin
      knownCode = 1'b1;
    end else if (cmdCode == cmc_pkg::CMD_VIN_TRIM) begin
      knownCode = 1'b1;
    end else if (cmdCode == cmc_pkg::CMD_VOUT_TRIM) begin
      knownCode = 1'b1;
    end else if (cmdCode == cmc_pkg::CMD_REG_OPTS) begin
      knownCode = 1'b1;
    end else if (cmdCode == cmc_pkg::CMD_INT_TOFS) begin
      knownCode = 1'b1;
    end else if (cmdCode == cmc_pkg::CMD_EXT_TCAL) begin
      knownCode = 1'b1;
    end else if (cmdCode == cmc_pkg::CMD_REMOTE_CFG) begin
      knownCode = 1'b1;
    end else begin
      knownCode = 1'b0;
    end
  end

  // A write without a valid checksum is refused while the check is demanded,
  // so while it is demanded a corrupted transfer cannot alter the configuration.
  assign pecBlocked = cmdWrite & regOpts_reg[cmc_pkg::OPT_PEC_BIT] & ~cmdPecOk;
  assign wrStrobe = cmdValid & cmdWrite & knownCode & ~pecBlocked;

  // -----------------------------------------------------------------------
  // Event record pointer
  // -----------------------------------------------------------------------
  // The newest life record sits just below base plus the stored count; with a count of zero it is the base itself.
  always_comb begin
    if (lifeRecordCount == 5'h00) begin
      newestLifeIdx = cmc_pkg::EVT_LIFE_BASE;
    end else begin
      newestLifeIdx = cmc_pkg::EVT_LIFE_BASE + {3'h0, lifeRecordCount} - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eventPtr_reg <= cmc_pkg::RST_EVENT_PTR;
    end else if (wrStrobe && cmdCode == cmc_pkg::CMD_EVENT_PTR) begin
      if (cmdWrData[7:0] <= cmc_pkg::EVT_IDX_MAX) begin
        eventPtr_reg <= cmdWrData[7:0];
      end else if (cmdWrData[7:0] == cmc_pkg::EVT_NEWEST_LIFE) begin
        eventPtr_reg <= newestLifeIdx;
      end else if (cmdWrData[7:0] == cmc_pkg::EVT_CLEAR_FAULT) begin
        eventPtr_reg <= cmc_pkg::EVT_FAULT_OLDEST;
      end
      // Codes 48 to 253 leave the pointer as it was.
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      faultClear <= 1'b0;
    end else begin
      faultClear <= wrStrobe && cmdCode == cmc_pkg::CMD_EVENT_PTR &&
                    cmdWrData[7:0] == cmc_pkg::EVT_CLEAR_FAULT;
    end
  end

  // Split the index into a section and an age offset inside that section.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eventIdx <= cmc_pkg::RST_EVENT_PTR;
      eventLifeSection <= 1'b0;
      eventOffset <= 8'h00;
    end else begin
      eventIdx <= eventPtr_reg;
      if (eventPtr_reg >= cmc_pkg::EVT_LIFE_BASE) begin
        eventLifeSection <= 1'b1;
        eventOffset <= eventPtr_reg - cmc_pkg::EVT_LIFE_BASE;
      end else begin
        eventLifeSection <= 1'b0;
        eventOffset <= eventPtr_reg;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Temperature sensor select and calibration
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tempSel_reg <= cmc_pkg::RST_TEMP_SEL;
    end else if (wrStrobe && cmdCode == cmc_pkg::CMD_TEMP_SEL) begin
      // Only the source bit is kept; the rest reads as zero.
      tempSel_reg <= {7'h00, cmdWrData[cmc_pkg::TSEL_EXT_BIT]};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intTempOfs_reg <= cmc_pkg::RST_INT_TOFS;
    end else if (wrStrobe && cmdCode == cmc_pkg::CMD_INT_TOFS) begin
      intTempOfs_reg <= cmdWrData[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      extTempCal_reg <= cmc_pkg::RST_EXT_TCAL;
    end else if (wrStrobe && cmdCode == cmc_pkg::CMD_EXT_TCAL) begin
      extTempCal_reg <= cmdWrData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      useExternalSensor <= 1'b0;
    end else begin
      useExternalSensor <= tempSel_reg[cmc_pkg::TSEL_EXT_BIT];
    end
  end

  cmc_temp_calc u_temp (
    .clk(clk),
    .nrst(nrst),
    .useExternal(tempSel_reg[cmc_pkg::TSEL_EXT_BIT]),
    .intOffset(intTempOfs_reg),
    .extCal(extTempCal_reg),
    .intTempRaw(intTempRaw),
    .extAdcRaw(extAdcRaw),
    .tempOut(tempReading)
  );

  // -----------------------------------------------------------------------
  // Voltage trims
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vinTrim_reg <= cmc_pkg::RST_VIN_TRIM;
    end else if (wrStrobe && cmdCode == cmc_pkg::CMD_VIN_TRIM) begin
      vinTrim_reg <= cmdWrData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      voutTrim_reg <= cmc_pkg::RST_VOUT_TRIM;
    end else if (wrStrobe && cmdCode == cmc_pkg::CMD_VOUT_TRIM) begin
      voutTrim_reg <= cmdWrData[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vinTrimOn <= 16'h0000;
      vinTrimOff <= 16'h0000;
      voutTrim <= 16'h0000;
    end else begin
      vinTrimOn <= vinTrim_reg[cmc_pkg::TRIM_ON_MSB:cmc_pkg::TRIM_ON_LSB];
      vinTrimOff <= vinTrim_reg[cmc_pkg::TRIM_OFF_MSB:cmc_pkg::TRIM_OFF_LSB];
      voutTrim <= voutTrim_reg;
    end
  end

  // -----------------------------------------------------------------------
  // Regulation options
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regOpts_reg <= cmc_pkg::RST_REG_OPTS;
    end else if (wrStrobe && cmdCode == cmc_pkg::CMD_REG_OPTS) begin
      // Reserved bits 1:0 and unused bit 4 are never stored.
      regOpts_reg <= cmdWrData[7:0] & cmc_pkg::OPT_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pecRequired <= 1'b0;
      hybridRatioMode <= 1'b0;
      droopSlopeShape <= 1'b0;
      adaptiveRampLoadComp <= 1'b0;
      dynamicBusVoltageMode <= 1'b0;
    end else begin
      pecRequired <= regOpts_reg[cmc_pkg::OPT_PEC_BIT];
      hybridRatioMode <= regOpts_reg[cmc_pkg::OPT_HRR_BIT];
      droopSlopeShape <= regOpts_reg[cmc_pkg::OPT_DLS_BIT];
      adaptiveRampLoadComp <= regOpts_reg[cmc_pkg::OPT_ARD_BIT];
      dynamicBusVoltageMode <= regOpts_reg[cmc_pkg::OPT_DBV_BIT];
    end
  end

  // -----------------------------------------------------------------------
  // Remote on/off configuration
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remoteCfg_reg <= cmc_pkg::RST_REMOTE_CFG;
    end else if (wrStrobe && cmdCode == cmc_pkg::CMD_REMOTE_CFG) begin
      remoteCfg_reg <= cmdWrData[7:0] & cmc_pkg::RC_WRITE_MASK;
    end
  end

  cmc_remote_ctl u_remote (
    .clk(clk),
    .nrst(nrst),
    .cfg(remoteCfg_reg),
    .remoteIn(primaryRemoteInput),
    .ctrlIn(ctrlPin),
    .opOn(operationOn),
    .outputOn(outputOn),
    .softStopReq(softStopReq),
    .quickOffReq(quickOffReq)
  );

  // -----------------------------------------------------------------------
  // Read path and response
  // -----------------------------------------------------------------------
  always_comb begin
    if (cmdCode == cmc_pkg::CMD_EVENT_PTR) begin
      rdValue = {24'h000000, eventPtr_reg};
    end else if (cmdCode == cmc_pkg::CMD_TEMP_SEL) begin
      rdValue = {24'h000000, tempSel_reg};
    end else if (cmdCode == cmc_pkg::CMD_VIN_TRIM) begin
      rdValue = vinTrim_reg;
    end else if (cmdCode == cmc_pkg::CMD_VOUT_TRIM) begin
      rdValue = {16'h0000, voutTrim_reg};
    end else if (cmdCode == cmc_pkg::CMD_REG_OPTS) begin
      rdValue = {24'h000000, regOpts_reg};
    end else if (cmdCode == cmc_pkg::CMD_INT_TOFS) begin
      rdValue = {16'h0000, intTempOfs_reg};
    end else if (cmdCode == cmc_pkg::CMD_EXT_TCAL) begin
      rdValue = extTempCal_reg;
    end else if (cmdCode == cmc_pkg::CMD_REMOTE_CFG) begin
      rdValue = {24'h000000, remoteCfg_reg};
    end else begin
      rdValue = 32'h0000_0000;
    end
  end

  // Unknown codes and unchecked writes answer with a refusal and zero data.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rspValid <= 1'b0;
      rspNack <= 1'b0;
      rspData <= 32'h0000_0000;
    end else begin
      rspValid <= cmdValid;
      rspNack <= cmdValid & (~knownCode | pecBlocked);
      if (cmdValid && !cmdWrite) begin
        rspData <= rdValue;
      end else begin
        rspData <= 32'h0000_0000;
      end
    end
  end

endmodule // cmc_config_regs

// ### core/cmc_pkg.sv
// Purpose: Shared constants for the converter configuration register bank.
// Assumes: Command codes arrive already decoded from the PMBus transport.
// Notes:   Every offset, field position, reset value and code lives here.
package cmc_pkg;

  // ---------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMD_EVENT_PTR = 8'hdb;
  localparam logic [7:0] CMD_TEMP_SEL = 8'hdc;
  localparam logic [7:0] CMD_VIN_TRIM = 8'hdd;
  localparam logic [7:0] CMD_VOUT_TRIM = 8'hde;
  localparam logic [7:0] CMD_REG_OPTS = 8'he0;
  localparam logic [7:0] CMD_INT_TOFS = 8'he1;
  localparam logic [7:0] CMD_EXT_TCAL = 8'he2;
  localparam logic [7:0] CMD_REMOTE_CFG = 8'he3;

  // ---------------------------------------------------------------------
  // Event pointer codes
  // ---------------------------------------------------------------------
  localparam logic [7:0] EVT_IDX_MAX = 8'h2f;
  localparam logic [7:0] EVT_NEWEST_LIFE = 8'hfe;
  localparam logic [7:0] EVT_CLEAR_FAULT = 8'hff;
  localparam logic [7:0] EVT_LIFE_BASE = 8'h18;
  localparam logic [7:0] EVT_FAULT_OLDEST = 8'h00;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int TSEL_EXT_BIT = 0;
  localparam int OPT_PEC_BIT = 7;
  localparam int OPT_HRR_BIT = 6;
  localparam int OPT_DLS_BIT = 5;
  localparam int OPT_ARD_BIT = 3;
  localparam int OPT_DBV_BIT = 2;
  localparam logic [7:0] OPT_WRITE_MASK = 8'hec;
  localparam int RC_AND_BIT = 4;
  localparam int RC_PIN_EN_BIT = 2;
  localparam int RC_POL_BIT = 1;
  localparam int RC_QUICK_BIT = 0;
  localparam logic [7:0] RC_WRITE_MASK = 8'h17;
  localparam int TRIM_ON_MSB = 31;
  localparam int TRIM_ON_LSB = 16;
  localparam int TRIM_OFF_MSB = 15;
  localparam int TRIM_OFF_LSB = 0;
  localparam int TCAL_SLOPE_LSB = 16;
  localparam int TEMP_SLOPE_FRAC = 8;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_EVENT_PTR = 8'h00;
  localparam logic [7:0] RST_TEMP_SEL = 8'h00;
  localparam logic [31:0] RST_VIN_TRIM = 32'h0000_0000;
  localparam logic [15:0] RST_VOUT_TRIM = 16'h0000;
  localparam logic [7:0] RST_REG_OPTS = 8'h00;
  localparam logic [15:0] RST_INT_TOFS = 16'h0000;
  localparam logic [31:0] RST_EXT_TCAL = 32'h0100_0000;
  localparam logic [7:0] RST_REMOTE_CFG = 8'h00;

  // Remote on/off state.
  typedef enum logic [1:0] {
    RC_OFF = 2'b01,
    RC_ON = 2'b10
  } cmc_rc_state_t;

endpackage

// ### core/cmc_temp_calc.sv
// Purpose: Temperature reading from the selected sensor with calibration.
// Assumes: Sensor samples come from logic on the same clock.
// Notes:   External slope is signed with TEMP_SLOPE_FRAC fraction bits.
module cmc_temp_calc (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration
  input wire logic useExternal,
  input wire logic [15:0] intOffset,
  input wire logic [31:0] extCal,
  // Samples
  input wire logic [15:0] intTempRaw,
  input wire logic [15:0] extAdcRaw,
  // Result
  output logic [15:0] tempOut
);

  logic signed [32:0] extProd;
  logic signed [32:0] extScaled;
  logic [15:0] extTemp;
  logic [15:0] intTemp;

  // Internal offset is a signed count of 0.1 degC added to the raw reading.
  assign intTemp = intTempRaw + intOffset;
  // Temperature equals slope times ADC reading plus offset.
  assign extProd = $signed(extCal[31:cmc_pkg::TCAL_SLOPE_LSB]) *
                   $signed({1'b0, extAdcRaw});
  assign extScaled = extProd >>> cmc_pkg::TEMP_SLOPE_FRAC;
  assign extTemp = extScaled[15:0] + extCal[15:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tempOut <= 16'h0000;
    end else begin
      tempOut <= useExternal ? extTemp : intTemp;
    end
  end

endmodule // cmc_temp_calc

// ### core/cmc_remote_ctl.sv
// Purpose: Combines the remote input pin with the on/off sources.
// Assumes: remoteIn and ctrlIn are asynchronous pins; opOn is on-clock.
// Notes:   Each stop request is a one-cycle pulse at the on-to-off edge.
module cmc_remote_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration
  input wire logic [7:0] cfg,
  // Sources
  input wire logic remoteIn,
  input wire logic ctrlIn,
  input wire logic opOn,
  // Results
  output logic outputOn,
  output logic softStopReq,
  output logic quickOffReq
);

  logic [1:0] remoteSync;
  logic [1:0] ctrlSync;
  logic remoteActive;
  logic onCmd;
  cmc_pkg::cmc_rc_state_t state;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remoteSync <= 2'b00;
      ctrlSync <= 2'b00;
    end else begin
      remoteSync <= {remoteSync[0], remoteIn};
      ctrlSync <= {ctrlSync[0], ctrlIn};
    end
  end

  // Polarity follows the value table: 1 active high, 0 active low.
  assign remoteActive = cfg[cmc_pkg::RC_POL_BIT] ? remoteSync[1] : ~remoteSync[1];

  always_comb begin
    if (!cfg[cmc_pkg::RC_PIN_EN_BIT]) begin
      onCmd = opOn & ctrlSync[1];
    end else if (cfg[cmc_pkg::RC_AND_BIT]) begin
      onCmd = remoteActive & opOn & ctrlSync[1];
    end else begin
      onCmd = remoteActive | opOn | ctrlSync[1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= cmc_pkg::RC_OFF;
      outputOn <= 1'b0;
      softStopReq <= 1'b0;
      quickOffReq <= 1'b0;
    end else begin
      softStopReq <= 1'b0;
      quickOffReq <= 1'b0;
      case (state)
        cmc_pkg::RC_OFF: begin
          if (onCmd) begin
            state <= cmc_pkg::RC_ON;
            outputOn <= 1'b1;
          end
        end
        cmc_pkg::RC_ON: begin
          if (!onCmd) begin
            state <= cmc_pkg::RC_OFF;
            outputOn <= 1'b0;
            softStopReq <= ~cfg[cmc_pkg::RC_QUICK_BIT];
            quickOffReq <= cfg[cmc_pkg::RC_QUICK_BIT];
          end
        end
        default: begin
          state <= cmc_pkg::RC_OFF;
          outputOn <= 1'b0;
        end
      endcase
    end
  end

endmodule // cmc_remote_ctl

// ### tb/cmc_config_regs_asserts.sv
// Purpose: Port-level checks of the configuration register bank.
// Assumes: One clock domain; nrst low disables every check.
// Notes:   A write counts as taken unless the check byte is demanded and bad.
module cmc_config_regs_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command and response
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [31:0] cmdWrData,
  input wire logic cmdPecOk,
  input wire logic rspValid,
  input wire logic rspNack,
  // Watched outputs
  input wire logic [7:0] eventIdx,
  input wire logic eventLifeSection,
  input wire logic faultClear,
  input wire logic useExternalSensor,
  input wire logic pecRequired,
  input wire logic hybridRatioMode,
  input wire logic droopSlopeShape,
  input wire logic adaptiveRampLoadComp,
  input wire logic dynamicBusVoltageMode,
  input wire logic softStopReq,
  input wire logic quickOffReq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wrOk;
  logic ptrWr;
  assign wrOk = cmdValid && cmdWrite && (!pecRequired || cmdPecOk);
  assign ptrWr = wrOk && cmdCode == cmc_pkg::CMD_EVENT_PTR;

  chk_rsp_once: assert property (
    rspValid == $past(cmdValid)) else $error("response count off");
  chk_pec_refuse: assert property (
    cmdValid && cmdWrite && pecRequired && !cmdPecOk |=> rspNack)
    else $error("unchecked write taken");
  chk_ptr_echo: assert property (
    ptrWr && cmdWrData[7:0] <= 8'h2f |=> ##1 eventIdx == $past(cmdWrData[7:0], 2))
    else $error("pointer not echoed");
  chk_ptr_ignore: assert property (
    ptrWr && cmdWrData[7:0] inside {[8'h30:8'hfd]} |=> ##1 $stable(eventIdx))
    else $error("undefined pointer code taken");
  chk_newest_life: assert property (
    ptrWr && cmdWrData[7:0] == 8'hfe |=> ##1 eventLifeSection && eventIdx >= 8'h18)
    else $error("newest code missed life section");
  chk_clear_pulse: assert property (
    ptrWr && cmdWrData[7:0] == 8'hff |=> faultClear ##1 eventIdx == 8'h00)
    else $error("fault clear missing");
  chk_sensor_sel: assert property (
    wrOk && cmdCode == cmc_pkg::CMD_TEMP_SEL |=> ##1
    useExternalSensor == $past(cmdWrData[0], 2)) else $error("sensor select wrong");
  chk_opt_bits: assert property (
    wrOk && cmdCode == cmc_pkg::CMD_REG_OPTS |=> ##1
    {pecRequired, hybridRatioMode, droopSlopeShape, adaptiveRampLoadComp,
    dynamicBusVoltageMode} == $past({cmdWrData[7:5], cmdWrData[3:2]}, 2))
    else $error("option outputs wrong");
  chk_stop_excl: assert property (
    !(softStopReq && quickOffReq)) else $error("both stop kinds at once");
endmodule // cmc_config_regs_asserts

bind cmc_config_regs cmc_config_regs_asserts i_chk (.clk, .nrst, .cmdValid, .cmdWrite,
  .cmdCode, .cmdWrData, .cmdPecOk, .rspValid, .rspNack, .eventIdx, .eventLifeSection,
  .faultClear, .useExternalSensor, .pecRequired, .hybridRatioMode, .droopSlopeShape,
  .adaptiveRampLoadComp, .dynamicBusVoltageMode, .softStopReq, .quickOffReq);

// ### tb/cmc_host_model.sv
// Purpose: Bus host that issues decoded commands to the register bank.
// Assumes: Commands change on the falling edge; answers come one cycle on.
// Notes:   Data is passed untouched, so reserved bits mean nothing here.
module cmc_host_model (
  // Clock
  input wire logic clk,
  // Command
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [31:0] cmdWrData,
  output logic cmdPecOk,
  // Response
  input wire logic rspNack,
  input wire logic [31:0] rspData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdWrData = 32'h0;
    cmdPecOk = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [31:0] d,
      input logic pec, output logic nack, output logic [31:0] q);
    @(negedge clk);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdCode = c;
    cmdWrData = d;
    cmdPecOk = pec;
    @(negedge clk);
    nack = rspNack;
    q = rspData;
    // Qualifiers are scrambled once released, so a stale one never passes.
    cmdValid = 1'b0;
    cmdWrite = ~wr;
    cmdCode = ~c;
    cmdWrData = ~d;
    cmdPecOk = ~pec;
  endtask
endmodule // cmc_host_model

// ### tb/test_converter_mfr_config_registers.sv
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Inputs change on the falling edge of a 250 MHz clock.
// Notes:   Derived levels are judged two edges after the write; the temperature reading three.
module test_converter_mfr_config_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, cmdValid, cmdWrite, cmdPecOk, rspValid, rspNack, eventLifeSection;
  logic [7:0] cmdCode, eventIdx, eventOffset;
  logic [31:0] cmdWrData, rspData;
  logic [4:0] lifeRecordCount;
  logic faultClear, useExternalSensor, pecRequired, hybridRatioMode, droopSlopeShape;
  logic adaptiveRampLoadComp, dynamicBusVoltageMode, primaryRemoteInput, ctrlPin;
  logic operationOn, outputOn, softStopReq, quickOffReq;
  logic [15:0] intTempRaw, extAdcRaw, tempReading, vinTrimOn, vinTrimOff, voutTrim;
  int error_cnt, checks_done, clrCnt, softCnt, quickCnt;

  cmc_config_regs i_dut (.clk, .nrst, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData,
    .cmdPecOk, .rspValid, .rspNack, .rspData, .lifeRecordCount, .eventIdx,
    .eventLifeSection, .eventOffset, .faultClear, .intTempRaw, .extAdcRaw,
    .useExternalSensor, .tempReading, .vinTrimOn, .vinTrimOff, .voutTrim, .pecRequired,
    .hybridRatioMode, .droopSlopeShape, .adaptiveRampLoadComp, .dynamicBusVoltageMode,
    .primaryRemoteInput, .ctrlPin, .operationOn, .outputOn, .softStopReq, .quickOffReq);
  cmc_host_model i_host (.clk, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData, .cmdPecOk,
    .rspNack, .rspData);

  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (faultClear === 1'b1) clrCnt++;
    if (softStopReq === 1'b1) softCnt++;
    if (quickOffReq === 1'b1) quickCnt++;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    checks_done++;
    if (got !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] c, input logic [31:0] d);
    logic n;
    logic [31:0] q;
    i_host.xfer(1'b1, c, d, 1'b1, n, q);
    chk("write nack", 32'h0, {31'h0, n});
  endtask
  task automatic rd(input logic [7:0] c, input logic [31:0] e);
    logic n;
    logic [31:0] q;
    i_host.xfer(1'b0, c, 32'h0, 1'b1, n, q);
    chk("read nack", 32'h0, {31'h0, n});
    chk("read data", e, q);
  endtask
  task automatic pins(input logic r, input logic o, input logic c, input logic e);
    @(negedge clk);
    primaryRemoteInput = r;
    operationOn = o;
    ctrlPin = c;
    settle(6);
    chk("outputOn", {31'h0, e}, {31'h0, outputOn});
  endtask

  // -----------------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------------
  task automatic t_reset;
    logic n;
    logic [31:0] q;
    rd(cmc_pkg::CMD_EVENT_PTR, {24'h0, cmc_pkg::RST_EVENT_PTR});
    rd(cmc_pkg::CMD_VIN_TRIM, cmc_pkg::RST_VIN_TRIM);
    rd(cmc_pkg::CMD_EXT_TCAL, cmc_pkg::RST_EXT_TCAL);
    i_host.xfer(1'b0, 8'hdf, 32'h0, 1'b1, n, q);
    chk("unmapped nack", 32'h1, {31'h0, n});
    $display("test reset done");
  endtask
  task automatic t_pointer;
    int c0;
    wr(cmc_pkg::CMD_EVENT_PTR, 32'h18);
    settle(2);
    chk("life section", 32'h1, {31'h0, eventLifeSection});
    chk("life offset", 32'h0, {24'h0, eventOffset});
    wr(cmc_pkg::CMD_EVENT_PTR, 32'h2f);
    rd(cmc_pkg::CMD_EVENT_PTR, 32'h2f);
    wr(cmc_pkg::CMD_EVENT_PTR, 32'h30);
    wr(cmc_pkg::CMD_EVENT_PTR, 32'hfd);
    rd(cmc_pkg::CMD_EVENT_PTR, 32'h2f);
    lifeRecordCount = 5'h05;
    wr(cmc_pkg::CMD_EVENT_PTR, 32'hfe);
    settle(2);
    chk("newest index", 32'h1c, {24'h0, eventIdx});
    chk("newest offset", 32'h4, {24'h0, eventOffset});
    lifeRecordCount = 5'h00;
    wr(cmc_pkg::CMD_EVENT_PTR, 32'hfe);
    rd(cmc_pkg::CMD_EVENT_PTR, 32'h18);
    c0 = clrCnt;
    wr(cmc_pkg::CMD_EVENT_PTR, 32'hff);
    settle(2);
    chk("clear pulses", 32'h1, clrCnt - c0);
    chk("fault oldest", 32'h0, {24'h0, eventIdx});
    $display("test pointer done");
  endtask
  task automatic t_trims;
    wr(cmc_pkg::CMD_VIN_TRIM, 32'h1234abcd);
    wr(cmc_pkg::CMD_VOUT_TRIM, 32'hffff8001);
    settle(2);
    chk("trim on", 32'h1234, {16'h0, vinTrimOn});
    chk("trim off", 32'habcd, {16'h0, vinTrimOff});
    chk("vout trim", 32'h8001, {16'h0, voutTrim});
    rd(cmc_pkg::CMD_VOUT_TRIM, 32'h8001);
    $display("test trims done");
  endtask
  task automatic t_options;
    logic n;
    logic [31:0] q;
    wr(cmc_pkg::CMD_REG_OPTS, 32'hff);
    rd(cmc_pkg::CMD_REG_OPTS, 32'hec);
    i_host.xfer(1'b1, cmc_pkg::CMD_REG_OPTS, 32'h0, 1'b0, n, q);
    chk("unchecked write nack", 32'h1, {31'h0, n});
    settle(2);
    chk("check demanded", 32'h1, {31'h0, pecRequired});
    wr(cmc_pkg::CMD_REG_OPTS, 32'h24);
    settle(2);
    chk("options a", 32'h5, {27'h0, pecRequired, hybridRatioMode, droopSlopeShape,
      adaptiveRampLoadComp, dynamicBusVoltageMode});
    wr(cmc_pkg::CMD_REG_OPTS, 32'h48);
    settle(2);
    chk("options b", 32'ha, {27'h0, pecRequired, hybridRatioMode, droopSlopeShape,
      adaptiveRampLoadComp, dynamicBusVoltageMode});
    $display("test options done");
  endtask
  task automatic t_temp;
    wr(cmc_pkg::CMD_INT_TOFS, 32'h000a);
    settle(3);
    chk("internal temp", 32'h6e, {16'h0, tempReading});
    wr(cmc_pkg::CMD_EXT_TCAL, 32'h02000005);
    wr(cmc_pkg::CMD_TEMP_SEL, 32'hffffffff);
    settle(3);
    chk("external sel", 32'h1, {31'h0, useExternalSensor});
    chk("external temp", 32'h69, {16'h0, tempReading});
    rd(cmc_pkg::CMD_TEMP_SEL, 32'h1);
    $display("test temperature done");
  endtask
  task automatic t_remote;
    int s0;
    int q0;
    s0 = softCnt;
    q0 = quickCnt;
    wr(cmc_pkg::CMD_REMOTE_CFG, 32'h0);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    chk("soft stops", 32'h1, softCnt - s0);
    wr(cmc_pkg::CMD_REMOTE_CFG, 32'h16);
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    wr(cmc_pkg::CMD_REMOTE_CFG, 32'h05);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk("quick stops", 32'h1, quickCnt - q0);
    wr(cmc_pkg::CMD_REMOTE_CFG, 32'hff);
    rd(cmc_pkg::CMD_REMOTE_CFG, 32'h17);
    $display("test remote done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #20us;
    error_cnt++;
    $display("BAD watchdog expected done seen hang");
    wrap_up();
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    lifeRecordCount = 5'h00;
    intTempRaw = 16'h0064;
    extAdcRaw = 16'h0032;
    primaryRemoteInput = 1'b0;
    ctrlPin = 1'b1;
    operationOn = 1'b1;
    settle(2);
    nrst = 1'b1;
    t_reset();
    t_pointer();
    t_trims();
    t_options();
    t_temp();
    t_remote();
    wrap_up();
  end
endmodule // test_converter_mfr_config_registers
